// ===== logic/deser_cfg_pkg.sv
/*
  Shared constants and carrier types for the deserializer strap, status and
  control-channel mode logic. Assumes a 200 MHz system clock.
*/
package deser_cfg_pkg;

  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned SPREAD_PERCENT = 2;
  localparam int unsigned FAST_PCLK_MAX_MHZ = 104;
  localparam int unsigned WIDE_PCLK_MAX_MHZ = 78;
  localparam int unsigned AUDIO_RATE_MIN_KHZ = 32;
  localparam int unsigned AUDIO_RATE_MAX_KHZ = 192;
  localparam int unsigned AUDIO_DEPTH_MIN = 8;
  localparam int unsigned AUDIO_DEPTH_MAX = 32;
  localparam int unsigned AUDIO_TDM_CHANNELS = 8;

  // Three-level strap encoding.
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_HIGH = 2'h1;
  localparam logic [1:0] STRAP_OPEN = 2'h2;

  // Reset value of the captured straps.
  localparam logic [1:0] STRAP_RESET = 2'h0;

  // Three-level strap pin seen as two drive-detect bits.
  typedef struct packed {
    logic pulled_high;
    logic pulled_low;
  } tri_pin_t;

  typedef struct packed {
    logic [1:0] addr_1;
    logic [1:0] addr_0;
    logic spread_en;
    logic rate_slow;
  } strap_t;

  typedef enum logic [1:0] {
    MODE_BASE_I2C,
    MODE_BASE_UART,
    MODE_BYPASS_UART
  } ctrl_mode_t;

  typedef struct packed {
    ctrl_mode_t mode;
    logic full_duplex;
    logic proto_i2c;
    logic local_master;
  } ctrl_cfg_t;

endpackage

// ===== logic/deser_strap_status_ctrl.sv
/*
  Pin-level strap capture, status outputs and control-channel mode selection of
  a serial-link video deserializer. Assumes the link-side status and new A/V
  status events arrive on the recovered link clock, and the status read strobe
  and configuration pins arrive asynchronously to the system clock.
*/
module deser_strap_status_ctrl (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_link_clk,
  input wire logic i_link_rstn,
  input wire logic i_power_down_n,
  input wire logic i_aux_output_enable_in,
  input wire logic i_ctrl_protocol_select,
  input wire logic i_ctrl_direction_select,
  input wire logic i_ctrl_link_mode_select,
  input wire deser_cfg_pkg::tri_pin_t i_addr_strap_0,
  input wire deser_cfg_pkg::tri_pin_t i_addr_strap_1,
  input wire logic i_spread_enable_strap,
  input wire logic i_rate_select_strap,
  input wire logic i_link_pll_locked,
  input wire logic i_link_word_aligned,
  input wire logic i_link_data_error,
  input wire logic i_link_av_status_new,
  input wire logic i_av_status_read,
  input wire logic i_audio_mclk,
  input wire logic i_aux_control_0,
  input wire logic i_aux_control_3,
  output logic o_audio_mclk,
  output logic o_audio_mclk_oe,
  output logic o_aux_control_out_0,
  output logic o_aux_control_out_0_oe,
  output logic o_aux_control_out_3,
  output logic o_aux_control_out_3_oe,
  output logic o_av_status_irq_out,
  output logic o_av_status_irq_out_oe,
  output logic o_lock,
  output logic o_lock_oe,
  output logic o_error_n,
  output logic o_error_n_oe,
  output logic [1:0] o_addr_strap_0,
  output logic [1:0] o_addr_strap_1,
  output logic o_spread_enable,
  output logic o_rate_slow,
  output deser_cfg_pkg::ctrl_cfg_t o_ctrl_cfg
);
  localparam int unsigned N_PIN = 16;

  // Asynchronous pin levels into the system domain.
  logic [N_PIN-1:0] pin_raw;
  logic [N_PIN-1:0] pin_s;
  assign pin_raw = {i_power_down_n, i_aux_output_enable_in, i_ctrl_protocol_select,
                    i_ctrl_direction_select, i_ctrl_link_mode_select,
                    i_addr_strap_0, i_addr_strap_1, i_spread_enable_strap,
                    i_rate_select_strap, i_av_status_read, i_audio_mclk,
                    i_aux_control_0, i_aux_control_3, 1'b0};

  level_sync #(.WIDTH(N_PIN)) u_pin_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d(pin_raw),
    .o_q(pin_s)
  );

  logic power_down_n_n_s;
  logic oe_s;
  logic proto_s;
  logic dir_s;
  logic ms_s;
  deser_cfg_pkg::tri_pin_t addr_strap_0_s;
  deser_cfg_pkg::tri_pin_t addr_strap_1_s;
  logic spread_enable_strap_s;
  logic drs_s;
  logic rd_s;
  logic mclk_s;
  logic c0_s;
  logic c3_s;
  logic unused_s;
  assign {power_down_n_n_s, oe_s, proto_s, dir_s, ms_s, addr_strap_0_s, addr_strap_1_s, spread_enable_strap_s, drs_s,
          rd_s, mclk_s, c0_s, c3_s, unused_s} = pin_s;

  // Link-domain status: levels synchronised into the link clock first.
  logic [2:0] lk_raw;
  logic [2:0] lk_s;
  assign lk_raw = {i_link_pll_locked, i_link_word_aligned, i_link_data_error};

  level_sync #(.WIDTH(3)) u_link_sync (
    .i_clk(i_link_clk),
    .i_rstn(i_link_rstn),
    .i_d(lk_raw),
    .o_q(lk_s)
  );

  logic lk_good_r;
  logic lk_good_nxt;
  logic lk_err_r;
  logic lk_err_nxt;

  always_comb
  begin
    lk_good_nxt = lk_s[2] & lk_s[1];
    lk_err_nxt = lk_s[0];
  end

  always_ff @(posedge i_link_clk or negedge i_link_rstn)
  begin
    if (!i_link_rstn)
    begin
      lk_good_r <= 1'b0;
      lk_err_r <= 1'b0;
    end
    else
    begin
      lk_good_r <= lk_good_nxt;
      lk_err_r <= lk_err_nxt;
    end
  end

  logic [1:0] stat_s;
  level_sync #(.WIDTH(2)) u_stat_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d({lk_good_r, lk_err_r}),
    .o_q(stat_s)
  );

  // New status events cross from the link domain as a toggle.
  logic av_new;
  event_toggle_sync u_av_evt (
    .i_src_clk(i_link_clk),
    .i_src_rstn(i_link_rstn),
    .i_src_ce(1'b1),
    .i_src_pulse(i_link_av_status_new),
    .i_dst_clk(i_clk),
    .i_dst_rstn(i_rstn),
    .i_dst_ce(i_ce),
    .o_dst_pulse(av_new)
  );

  function automatic logic [1:0] tri_decode(input deser_cfg_pkg::tri_pin_t p);
    if (p.pulled_high)
      tri_decode = deser_cfg_pkg::STRAP_HIGH;
    else if (p.pulled_low)
      tri_decode = deser_cfg_pkg::STRAP_LOW;
    else
      tri_decode = deser_cfg_pkg::STRAP_OPEN;
  endfunction

  // Straps are captured on the first clock after reset release and on every
  // power-down exit.
  logic armed_r;
  logic armed_nxt;
  logic power_down_n_n_d_r;
  logic power_down_n_n_d_nxt;
  deser_cfg_pkg::strap_t strap_r;
  deser_cfg_pkg::strap_t strap_nxt;
  logic capture;

  always_comb
  begin
    capture = !armed_r || (power_down_n_n_s && !power_down_n_n_d_r);
    armed_nxt = 1'b1;
    power_down_n_n_d_nxt = power_down_n_n_s;
    strap_nxt = strap_r;
    if (capture)
    begin
      strap_nxt.addr_0 = tri_decode(addr_strap_0_s);
      strap_nxt.addr_1 = tri_decode(addr_strap_1_s);
      strap_nxt.spread_en = spread_enable_strap_s;
      strap_nxt.rate_slow = drs_s;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      armed_r <= 1'b0;
      power_down_n_n_d_r <= 1'b0;
      strap_r <= '{addr_1: deser_cfg_pkg::STRAP_RESET, addr_0: deser_cfg_pkg::STRAP_RESET,
                  spread_en: 1'b0, rate_slow: 1'b0};
    end
    else if (i_ce)
    begin
      armed_r <= armed_nxt;
      power_down_n_n_d_r <= power_down_n_n_d_nxt;
      strap_r <= strap_nxt;
    end
  end

  // Interrupt, status outputs, gated pins and control-channel mode.
  logic rd_d_r;
  logic rd_d_nxt;
  logic irq_r;
  logic irq_nxt;
  logic mclk_r;
  logic mclk_nxt;
  logic c0_r;
  logic c0_nxt;
  logic c3_r;
  logic c3_nxt;
  logic oe_r;
  logic oe_nxt;
  logic lock_r;
  logic lock_nxt;
  logic err_n_r;
  logic err_n_nxt;
  deser_cfg_pkg::ctrl_cfg_t cfg_r;
  deser_cfg_pkg::ctrl_cfg_t cfg_nxt;

  always_comb
  begin
    rd_d_nxt = rd_s;
    irq_nxt = irq_r;
    if (rd_s && !rd_d_r)
      irq_nxt = 1'b0;
    if (av_new)
      irq_nxt = 1'b1;
    oe_nxt = oe_s;
    mclk_nxt = mclk_s;
    c0_nxt = c0_s;
    c3_nxt = c3_s;
    lock_nxt = !power_down_n_n_s || stat_s[1];
    err_n_nxt = !power_down_n_n_s || !stat_s[0];
    cfg_nxt.local_master = dir_s;
    cfg_nxt.proto_i2c = proto_s;
    if (dir_s && ms_s)
      cfg_nxt.mode = deser_cfg_pkg::MODE_BYPASS_UART;
    else if (proto_s)
      cfg_nxt.mode = deser_cfg_pkg::MODE_BASE_I2C;
    else
      cfg_nxt.mode = deser_cfg_pkg::MODE_BASE_UART;
    cfg_nxt.full_duplex = (cfg_nxt.mode != deser_cfg_pkg::MODE_BASE_I2C);
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rd_d_r <= 1'b0;
      irq_r <= 1'b0;
      oe_r <= 1'b0;
      mclk_r <= 1'b0;
      c0_r <= 1'b0;
      c3_r <= 1'b0;
      lock_r <= 1'b1;
      err_n_r <= 1'b1;
      cfg_r <= '{mode: deser_cfg_pkg::MODE_BASE_UART, full_duplex: 1'b1,
                proto_i2c: 1'b0, local_master: 1'b0};
    end
    else if (i_ce)
    begin
      rd_d_r <= rd_d_nxt;
      irq_r <= irq_nxt;
      oe_r <= oe_nxt;
      mclk_r <= mclk_nxt;
      c0_r <= c0_nxt;
      c3_r <= c3_nxt;
      lock_r <= lock_nxt;
      err_n_r <= err_n_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  // Lock and error are open drain: they only ever pull low.
  assign o_audio_mclk = mclk_r;
  assign o_audio_mclk_oe = oe_r;
  assign o_aux_control_out_0 = c0_r;
  assign o_aux_control_out_0_oe = oe_r;
  assign o_aux_control_out_3 = c3_r;
  assign o_aux_control_out_3_oe = oe_r;
  assign o_av_status_irq_out = irq_r;
  assign o_av_status_irq_out_oe = oe_r;
  assign o_lock = 1'b0;
  assign o_lock_oe = !lock_r;
  assign o_error_n = 1'b0;
  assign o_error_n_oe = !err_n_r;
  assign o_addr_strap_0 = strap_r.addr_0;
  assign o_addr_strap_1 = strap_r.addr_1;
  assign o_spread_enable = strap_r.spread_en;
  assign o_rate_slow = strap_r.rate_slow;
  assign o_ctrl_cfg = cfg_r;
endmodule

// ===== logic/event_toggle_sync.sv
/*
  Carries one-cycle events from a source clock to a destination clock by a
  toggle. Assumes events are spaced wider than three destination clocks.
*/
module event_toggle_sync (
  input wire logic i_src_clk,
  input wire logic i_src_rstn,
  input wire logic i_src_ce,
  input wire logic i_src_pulse,
  input wire logic i_dst_clk,
  input wire logic i_dst_rstn,
  input wire logic i_dst_ce,
  output logic o_dst_pulse
);
  logic tog_r;
  logic tog_nxt;
  logic [2:0] dst_r;
  logic [2:0] dst_nxt;

  always_comb
  begin
    tog_nxt = tog_r ^ (i_src_ce & i_src_pulse);
  end

  always_ff @(posedge i_src_clk or negedge i_src_rstn)
  begin
    if (!i_src_rstn)
      tog_r <= 1'b0;
    else
      tog_r <= tog_nxt;
  end

  always_comb
  begin
    dst_nxt = i_dst_ce ? {dst_r[1:0], tog_r} : dst_r;
  end

  always_ff @(posedge i_dst_clk or negedge i_dst_rstn)
  begin
    if (!i_dst_rstn)
      dst_r <= 3'h0;
    else
      dst_r <= dst_nxt;
  end

  // Only the second and third stages feed the edge compare.
  assign o_dst_pulse = i_dst_ce & (dst_r[2] ^ dst_r[1]);
endmodule

// ===== logic/level_sync.sv
/*
  Two-flop synchroniser for a bus of levels into the destination clock.
  Assumes the inputs are levels that stay put for several destination clocks.
*/
module level_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      meta_r <= '0;
      q_r <= '0;
    end
    else
    begin
      meta_r <= i_d;
      q_r <= meta_r;
    end
  end

  assign o_q = q_r;
endmodule

// ===== sim/deser_strap_status_props.sv
/*
  Checker for the strap, status and mode block, bound to its ports.
  Assumes the clock enable is held high and inputs change clear of the edge.
*/
module deser_strap_status_props (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_power_down_n,
  input wire logic i_aux_output_enable_in,
  input wire logic i_ctrl_protocol_select,
  input wire logic i_ctrl_direction_select,
  input wire logic i_ctrl_link_mode_select,
  input wire logic i_spread_enable_strap,
  input wire logic i_rate_select_strap,
  input wire logic i_av_status_read,
  input wire logic i_aux_control_0,
  input wire logic o_audio_mclk_oe,
  input wire logic o_aux_control_out_0,
  input wire logic o_aux_control_out_0_oe,
  input wire logic o_aux_control_out_3_oe,
  input wire logic o_av_status_irq_out,
  input wire logic o_av_status_irq_out_oe,
  input wire logic o_lock,
  input wire logic o_lock_oe,
  input wire logic o_error_n,
  input wire logic o_error_n_oe,
  input wire logic [1:0] o_addr_strap_0,
  input wire logic [1:0] o_addr_strap_1,
  input wire logic o_spread_enable,
  input wire logic o_rate_slow,
  input wire deser_cfg_pkg::ctrl_cfg_t o_ctrl_cfg
);
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;

  // Counts the cycles after reset so that the depth-3 $past checks never look into reset.
  always_comb cnt_nxt = (cnt_r == 3'h4) ? cnt_r : cnt_r + 3'h1;
  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
      cnt_r <= 3'h0;
    else
      cnt_r <= cnt_nxt;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  AST_OE_FOLLOW: assert property (cnt_r == 3'h4 |-> o_audio_mclk_oe == $past(i_aux_output_enable_in, 3))
    else $error("output enable does not follow its pin");
  AST_OE_GROUP: assert property (o_audio_mclk_oe == o_aux_control_out_0_oe && o_aux_control_out_3_oe == o_av_status_irq_out_oe && o_aux_control_out_0_oe == o_av_status_irq_out_oe)
    else $error("gated outputs disagree on enable");
  AST_AUX_DATA: assert property (cnt_r == 3'h4 |-> o_aux_control_out_0 == $past(i_aux_control_0, 3))
    else $error("aux output 0 does not follow its source");
  AST_IRQ_CLEAR: assert property ($rose(i_av_status_read) |-> ##[3:4] !o_av_status_irq_out)
    else $error("interrupt not cleared by status read");
  AST_IRQ_HOLD: assert property ($fell(o_av_status_irq_out) |-> $past(i_av_status_read, 3) || $past(i_av_status_read, 4))
    else $error("interrupt dropped without a read");
  AST_STRAP_HOLD: assert property (cnt_r == 3'h4 && $changed({o_addr_strap_1, o_addr_strap_0, o_spread_enable, o_rate_slow}) |-> !$past(i_power_down_n, 5))
    else $error("straps changed outside power-down exit");
  AST_STRAP_LOAD: assert property ($rose(i_power_down_n) |-> ##5 {o_spread_enable, o_rate_slow} == {i_spread_enable_strap, i_rate_select_strap})
    else $error("spread or rate strap not captured");
  AST_PD_RELEASE: assert property (!i_power_down_n [*5] |-> !o_lock_oe && !o_error_n_oe && !o_lock)
    else $error("lock or error pulled low in power-down");
  AST_MODE: assert property (cnt_r == 3'h4 |-> o_ctrl_cfg.mode == (($past(i_ctrl_direction_select, 3) && $past(i_ctrl_link_mode_select, 3)) ? deser_cfg_pkg::MODE_BYPASS_UART : $past(i_ctrl_protocol_select, 3) ? deser_cfg_pkg::MODE_BASE_I2C : deser_cfg_pkg::MODE_BASE_UART))
    else $error("control mode wrong");
  AST_DUPLEX: assert property (o_ctrl_cfg.full_duplex == (o_ctrl_cfg.mode != deser_cfg_pkg::MODE_BASE_I2C))
    else $error("duplex flag wrong");
  AST_CFG_PINS: assert property (cnt_r == 3'h4 |-> o_ctrl_cfg.proto_i2c == $past(i_ctrl_protocol_select, 3) && o_ctrl_cfg.local_master == $past(i_ctrl_direction_select, 3))
    else $error("protocol or direction flag wrong");
  AST_OD_LOW: assert property (!o_lock && !o_error_n)
    else $error("open-drain data pin driven high");
endmodule

// ===== sim/link_side_model.sv
/*
  Link-side partner: status levels and new A/V status events on the
  recovered clock. Assumes the bench spaces events far apart.
*/
module link_side_model (
  input wire logic i_link_clk,
  output logic o_locked,
  output logic o_aligned,
  output logic o_data_error,
  output logic o_status_new
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {o_locked, o_aligned, o_data_error, o_status_new} = 4'h0;
  task automatic set_link(input logic l, input logic a, input logic e);
    @(posedge i_link_clk);
    o_locked <= l;
    o_aligned <= a;
    o_data_error <= e;
  endtask
  task automatic send_status();
    @(posedge i_link_clk);
    o_status_new <= 1'b1;
    @(posedge i_link_clk);
    o_status_new <= 1'b0;
  endtask
endmodule

// ===== sim/testbench.sv
/*
  Self-checking bench for the strap, status and mode block.
  Assumes the package and design files are compiled first.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rstn, i_ce, i_link_clk, i_link_rstn, i_power_down_n, i_aux_output_enable_in;
  logic i_ctrl_protocol_select, i_ctrl_direction_select, i_ctrl_link_mode_select;
  logic i_av_status_read, i_audio_mclk, i_aux_control_0, i_aux_control_3;
  logic i_link_pll_locked, i_link_word_aligned, i_link_data_error, i_link_av_status_new;
  logic o_audio_mclk, o_audio_mclk_oe, o_aux_control_out_0, o_aux_control_out_0_oe;
  logic o_aux_control_out_3, o_aux_control_out_3_oe, o_av_status_irq_out, o_av_status_irq_out_oe;
  logic o_lock, o_lock_oe, o_error_n, o_error_n_oe, o_spread_enable, o_rate_slow;
  logic [1:0] o_addr_strap_0, o_addr_strap_1;
  logic [5:0] strap_pins;
  logic [7:0] got, exp_s;
  deser_cfg_pkg::tri_pin_t i_addr_strap_0, i_addr_strap_1;
  logic i_spread_enable_strap, i_rate_select_strap;
  deser_cfg_pkg::ctrl_cfg_t o_ctrl_cfg;
  logic [7:0] exp_q[$];
  int id_q[$];
  int bad_count, comparisons;
  string names[5] = '{"irq", "lock pin", "error pin", "straps", "gated pins"};
  event look;
  assign {i_addr_strap_1, i_addr_strap_0, i_spread_enable_strap, i_rate_select_strap} = strap_pins;
  deser_strap_status_ctrl deser_strap_status_ctrl_i (.*);
  link_side_model link_side_model_i (.i_link_clk, .o_locked(i_link_pll_locked),
    .o_aligned(i_link_word_aligned), .o_data_error(i_link_data_error),
    .o_status_new(i_link_av_status_new));
  function automatic logic [1:0] lvl(input logic [1:0] p);
    return p[1] ? deser_cfg_pkg::STRAP_HIGH : p[0] ? deser_cfg_pkg::STRAP_LOW : deser_cfg_pkg::STRAP_OPEN;
  endfunction
  function automatic logic [7:0] straps_exp();
    return {2'h0, lvl(strap_pins[5:4]), lvl(strap_pins[3:2]), strap_pins[1:0]};
  endfunction
  function automatic logic [7:0] obs(input int id);
    case (id)
      0: return {7'h00, o_av_status_irq_out};
      1: return {7'h00, !o_lock_oe};
      2: return {7'h00, !o_error_n_oe};
      3: return {2'h0, o_addr_strap_1, o_addr_strap_0, o_spread_enable, o_rate_slow};
      default: return {4'h0, o_audio_mclk, o_aux_control_out_0, o_aux_control_out_3, o_audio_mclk_oe};
    endcase
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic expect_v(input int id, input logic [7:0] v);
    #1;
    id_q.push_back(id);
    exp_q.push_back(v);
    ->look;
  endtask
  task automatic read_status();
    @(posedge i_clk);
    i_av_status_read <= 1'b1;
    tick(6);
    i_av_status_read <= 1'b0;
    tick(6);
  endtask
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  initial
  begin
    i_link_clk = 1'b0;
    #7;
    forever #24 i_link_clk = ~i_link_clk;
  end
  initial
    forever
    begin
      @(look);
      got = obs(id_q[0]);
      comparisons++;
      if (got !== exp_q[0])
      begin
        bad_count++;
        $display("unexpected %s: expected %h, seen %h", names[id_q[0]], exp_q[0], got);
      end
      void'(id_q.pop_front());
      void'(exp_q.pop_front());
    end
  initial
  begin
    #100000;
    bad_count++;
    final_report();
  end
  initial
  begin
    {i_rstn, i_link_rstn, i_ce, i_power_down_n} = 4'h3;
    {i_aux_output_enable_in, i_ctrl_protocol_select, i_ctrl_direction_select} = 3'h0;
    {i_ctrl_link_mode_select, i_av_status_read, i_audio_mclk} = 3'h0;
    {i_aux_control_0, i_aux_control_3} = 2'h0;
    void'($urandom(32'h0000_4a26));
    strap_pins = 6'($urandom);
    tick(20);
    {i_rstn, i_link_rstn} <= 2'h3;
    tick(10);
    expect_v(3, straps_exp());
    link_side_model_i.set_link(1'b0, 1'b0, 1'b1);
    repeat (3)
    begin
      @(posedge i_clk);
      exp_s = straps_exp();
      strap_pins <= 6'($urandom);
      tick(10);
      expect_v(3, exp_s);
      i_power_down_n <= 1'b0;
      tick(10);
      expect_v(1, 8'h01);
      expect_v(2, 8'h01);
      @(posedge i_clk);
      i_power_down_n <= 1'b1;
      tick(10);
      expect_v(3, straps_exp());
    end
    for (int k = 0; k < 4; k++)
    begin
      link_side_model_i.set_link(k[1], k[0], k[0]);
      tick(80);
      expect_v(1, {7'h00, k[1] & k[0]});
      expect_v(2, {7'h00, !k[0]});
    end
    repeat (12)
    begin
      @(posedge i_clk);
      {i_aux_output_enable_in, i_ctrl_protocol_select, i_ctrl_direction_select,
        i_ctrl_link_mode_select, i_audio_mclk, i_aux_control_0, i_aux_control_3} <= 7'($urandom);
      tick(5);
      expect_v(4, {4'h0, i_audio_mclk, i_aux_control_0, i_aux_control_3, i_aux_output_enable_in});
    end
    repeat (2)
    begin
      link_side_model_i.send_status();
      tick(20);
      expect_v(0, 8'h01);
      read_status();
      expect_v(0, 8'h00);
      read_status();
      expect_v(0, 8'h00);
    end
    tick(5);
    final_report();
  end
endmodule
bind deser_strap_status_ctrl deser_strap_status_props deser_strap_status_props_i (.*);
